// ### tpl_params.svh
// register indices, field positions and reset values of the touch-probe latch
`ifndef TPL_PARAMS_SVH
`define TPL_PARAMS_SVH
// ==========================================
// register indices (byte address = 4 * index)
`define TPL_IDX_CTRL 16'h60b8
`define TPL_IDX_STAT 16'h60b9
`define TPL_IDX_POS_P1R 16'h60ba
`define TPL_IDX_POS_P1F 16'h60bb
`define TPL_IDX_POS_P2R 16'h60bc
`define TPL_IDX_POS_P2F 16'h60bd
`define TPL_IDX_CNT_P1R 16'h60d5
`define TPL_IDX_CNT_P1F 16'h60d6
`define TPL_IDX_CNT_P2R 16'h60d7
`define TPL_IDX_CNT_P2F 16'h60d8
`define TPL_IDX_POL 16'h2007
`define TPL_IDX_DIN 16'h60fd
`define TPL_IDX_IRQ_STAT 16'h7000
`define TPL_IDX_IRQ_CLR 16'h7001
`define TPL_IDX_IRQ_EN 16'h7002
// ==========================================
// control word fields, per probe, probe 2 at +stride
`define TPL_PROBE_STRIDE 8
`define TPL_CTL_EN 0
`define TPL_CTL_MODE 1
`define TPL_CTL_SRC 2
`define TPL_CTL_RISE 4
`define TPL_CTL_FALL 5
`define TPL_CTL_WMASK 16'h3737
// ==========================================
// status word fields, per probe
`define TPL_ST_EN 0
`define TPL_ST_RISE 1
`define TPL_ST_FALL 2
// ==========================================
// digital input status bits
`define TPL_DIN_A 26
`define TPL_DIN_B 27
// ==========================================
// reset values
`define TPL_RST_CTRL 16'h0000
`define TPL_RST_POL 2'h3
`define TPL_RST_IRQ_EN 4'h0
`endif

// ### tpl_pkg.sv
// types shared by the touch-probe latch
package tpl_pkg;
  // ==========================================
  // apb request carrier
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } tpl_apb_req_t;
  // ==========================================
  // one probe's slice of the control word
  typedef struct packed {
    logic en;
    logic cont;
    logic src_index;
    logic rise_en;
    logic fall_en;
  } tpl_probe_cfg_t;
endpackage

// ### tpl_probe_latch.sv
// two-channel touch-probe position latch with apb registers
// ==========================================
`timescale 1ns/1ps
`include "tpl_params.svh"
module tpl_probe_latch #(
  parameter int POS_W = 32,
  parameter int CNT_W = 32
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // apb slave
  input wire tpl_pkg::tpl_apb_req_t apb_req_i,
  output logic pready_o,
  output logic pslverr_o,
  output logic [31:0] prdata_o,
  // trigger sources and position
  input wire logic external_probe_input_a_i,
  input wire logic external_probe_input_b_i,
  input wire logic index_pulse_i,
  input wire logic [POS_W-1:0] position_i,
  // interrupt
  output logic irq_o
);
  // ==========================================
  // bus decode
  logic [15:0] idx;
  logic wr;
  logic rd_setup;
  logic [31:0] wmask;
  logic mapped;
  assign idx = apb_req_i.paddr[17:2];
  assign wr = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite;
  assign rd_setup = apb_req_i.psel & ~apb_req_i.penable;
  assign wmask = {{8{apb_req_i.pstrb[3]}}, {8{apb_req_i.pstrb[2]}},
                  {8{apb_req_i.pstrb[1]}}, {8{apb_req_i.pstrb[0]}}};
  // zero wait states: data is prepared in the setup cycle
  assign pready_o = 1'b1;
  always_comb begin
    case (idx)
      `TPL_IDX_CTRL, `TPL_IDX_STAT, `TPL_IDX_POS_P1R, `TPL_IDX_POS_P1F,
      `TPL_IDX_POS_P2R, `TPL_IDX_POS_P2F, `TPL_IDX_CNT_P1R, `TPL_IDX_CNT_P1F,
      `TPL_IDX_CNT_P2R, `TPL_IDX_CNT_P2F, `TPL_IDX_POL, `TPL_IDX_DIN,
      `TPL_IDX_IRQ_STAT, `TPL_IDX_IRQ_CLR, `TPL_IDX_IRQ_EN: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr_o = apb_req_i.psel & apb_req_i.penable & ~mapped;
  // ==========================================
  // software registers
  logic [15:0] ctrl;
  logic [1:0] pol;
  logic [3:0] irq_en;
  logic [15:0] next_ctrl;
  logic [31:0] wdat_ctl;
  assign wdat_ctl = ({16'h0000, ctrl} & ~wmask) | (apb_req_i.pwdata & wmask);
  assign next_ctrl = wdat_ctl[15:0] & `TPL_CTL_WMASK;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl <= `TPL_RST_CTRL;
    end else if (wr && idx == `TPL_IDX_CTRL) begin
      ctrl <= next_ctrl;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pol <= `TPL_RST_POL;
    end else if (wr && idx == `TPL_IDX_POL && apb_req_i.pstrb[0]) begin
      pol <= apb_req_i.pwdata[1:0];
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_en <= `TPL_RST_IRQ_EN;
    end else if (wr && idx == `TPL_IDX_IRQ_EN && apb_req_i.pstrb[0]) begin
      irq_en <= apb_req_i.pwdata[3:0];
    end
  end
  // ==========================================
  // per-probe configuration and trigger level
  tpl_pkg::tpl_probe_cfg_t cfg [2];
  logic [1:0] ext_lvl;
  logic [1:0] lvl;
  logic [1:0] prv;
  logic [1:0] cfg_chg;
  assign ext_lvl = {external_probe_input_b_i, external_probe_input_a_i};
  for (genvar p = 0; p < 2; p++) begin : g_probe
    localparam int B = p * `TPL_PROBE_STRIDE;
    assign cfg[p].en = ctrl[B + `TPL_CTL_EN];
    assign cfg[p].cont = ctrl[B + `TPL_CTL_MODE];
    assign cfg[p].src_index = ctrl[B + `TPL_CTL_SRC];
    assign cfg[p].rise_en = ctrl[B + `TPL_CTL_RISE];
    assign cfg[p].fall_en = ctrl[B + `TPL_CTL_FALL];
    // polarity bit high keeps the pin level as is
    assign lvl[p] = cfg[p].src_index ? index_pulse_i : (ext_lvl[p] ~^ pol[p]);
    // mode changes are left out on purpose: only enable, source and edges reset
    assign cfg_chg[p] = wr && idx == `TPL_IDX_CTRL &&
      ((next_ctrl[B +: 6] ^ ctrl[B +: 6]) & 6'h35) != 6'h00;
  end
  // inputs arrive synchronous to the clock, so one stage suffices for edges
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      prv <= 2'h0;
    end else begin
      prv <= lvl;
    end
  end
  // ==========================================
  // capture qualification, channel c = 2*probe + falling
  logic [3:0] edg;
  logic [3:0] cap;
  logic [3:0] flg;
  logic [3:0] clr;
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      edg[c] = (c % 2 == 0) ? (lvl[c/2] & ~prv[c/2]) : (~lvl[c/2] & prv[c/2]);
      cap[c] = edg[c] & cfg[c/2].en &
        ((c % 2 == 0) ? cfg[c/2].rise_en : cfg[c/2].fall_en) &
        (cfg[c/2].cont | ~flg[c]);
      clr[c] = cfg_chg[c/2];
    end
  end
  // ==========================================
  // latched positions, counters and executed flags
  logic [POS_W-1:0] pos_r [4];
  logic [CNT_W-1:0] cnt [4];
  always_ff @(posedge clk_sys_i) begin
    for (int c = 0; c < 4; c++) begin
      if (rst_i) begin
        pos_r[c] <= '0;
      end else if (cap[c]) begin
        pos_r[c] <= position_i;
      end
    end
  end
  always_ff @(posedge clk_sys_i) begin
    for (int c = 0; c < 4; c++) begin
      if (rst_i) begin
        cnt[c] <= '0;
      end else if (clr[c]) begin
        cnt[c] <= {{(CNT_W-1){1'b0}}, cap[c]};
      end else if (cap[c]) begin
        cnt[c] <= cnt[c] + 1'b1;
      end
    end
  end
  // a capture in the clearing cycle still leaves its flag set
  always_ff @(posedge clk_sys_i) begin
    for (int c = 0; c < 4; c++) begin
      if (rst_i) begin
        flg[c] <= 1'b0;
      end else if (cap[c]) begin
        flg[c] <= 1'b1;
      end else if (clr[c]) begin
        flg[c] <= 1'b0;
      end
    end
  end
  // ==========================================
  // status word and interrupt
  logic [15:0] stat;
  logic [3:0] irq_st;
  always_comb begin
    stat = 16'h0000;
    for (int p = 0; p < 2; p++) begin
      stat[p * `TPL_PROBE_STRIDE + `TPL_ST_EN] = cfg[p].en;
      stat[p * `TPL_PROBE_STRIDE + `TPL_ST_RISE] = flg[2*p];
      stat[p * `TPL_PROBE_STRIDE + `TPL_ST_FALL] = flg[2*p+1];
    end
  end
  always_ff @(posedge clk_sys_i) begin
    for (int c = 0; c < 4; c++) begin
      if (rst_i) begin
        irq_st[c] <= 1'b0;
      end else if (cap[c]) begin
        irq_st[c] <= 1'b1;
      end else if (wr && idx == `TPL_IDX_IRQ_CLR && apb_req_i.pstrb[0] && apb_req_i.pwdata[c]) begin
        irq_st[c] <= 1'b0;
      end
    end
  end
  assign irq_o = |(irq_st & irq_en);
  // ==========================================
  // read data, registered in the setup cycle
  logic [31:0] rd_mux;
  logic [31:0] din;
  always_comb begin
    din = 32'h00000000;
    din[`TPL_DIN_A] = external_probe_input_a_i;
    din[`TPL_DIN_B] = external_probe_input_b_i;
  end
  always_comb begin
    case (idx)
      `TPL_IDX_CTRL: rd_mux = {16'h0000, ctrl};
      `TPL_IDX_STAT: rd_mux = {16'h0000, stat};
      `TPL_IDX_POS_P1R: rd_mux = 32'(pos_r[0]);
      `TPL_IDX_POS_P1F: rd_mux = 32'(pos_r[1]);
      `TPL_IDX_POS_P2R: rd_mux = 32'(pos_r[2]);
      `TPL_IDX_POS_P2F: rd_mux = 32'(pos_r[3]);
      `TPL_IDX_CNT_P1R: rd_mux = 32'(cnt[0]);
      `TPL_IDX_CNT_P1F: rd_mux = 32'(cnt[1]);
      `TPL_IDX_CNT_P2R: rd_mux = 32'(cnt[2]);
      `TPL_IDX_CNT_P2F: rd_mux = 32'(cnt[3]);
      `TPL_IDX_POL: rd_mux = {30'h0, pol};
      `TPL_IDX_DIN: rd_mux = din;
      `TPL_IDX_IRQ_STAT: rd_mux = {28'h0000000, irq_st};
      `TPL_IDX_IRQ_EN: rd_mux = {28'h0000000, irq_en};
      default: rd_mux = 32'h00000000;
    endcase
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      prdata_o <= 32'h00000000;
    end else if (rd_setup) begin
      prdata_o <= rd_mux;
    end
  end
  // ==========================================
  // assertions
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  cap_pos_a: assert property (cap[0] |=> pos_r[0] == $past(position_i))
    else $error("probe 1 rising capture stored wrong position");
  hold_pos_a: assert property (!cap[3] |=> $stable(pos_r[3]))
    else $error("probe 2 falling position changed without capture");
  cnt_inc_a: assert property (cap[1] && !clr[1] |=> cnt[1] == $past(cnt[1]) + 1)
    else $error("probe 1 falling counter did not step");
  cnt_clr_a: assert property (clr[2] && !cap[2] |=> cnt[2] == 0 && !flg[2])
    else $error("config change did not clear probe 2 rising");
  single_once_a: assert property (!cfg[0].cont && flg[0] |-> !cap[0])
    else $error("single mode captured a second edge");
  cont_keep_a: assert property (cfg[1].cont && cfg[1].en && cfg[1].rise_en && edg[2] |-> cap[2])
    else $error("continuous mode missed an edge");
  disabled_a: assert property (!ctrl[0] |-> !cap[0] && !cap[1])
    else $error("disabled probe 1 captured");
  mirror_en_a: assert property (stat[8] == ctrl[8] && stat[0] == ctrl[0])
    else $error("status enable does not mirror control");
  rise_gate_a: assert property (cap[0] |-> ctrl[4])
    else $error("probe 1 rising captured while disabled");
  fall_gate_a: assert property (cap[1] |-> ctrl[5])
    else $error("probe 1 falling captured while disabled");
  p2_gate_a: assert property ((cap[2] |-> ctrl[12]) and (cap[3] |-> ctrl[13]))
    else $error("probe 2 edge captured while disabled");
  flag_set_a: assert property (cap[0] |=> stat[1])
    else $error("probe 1 rising flag not set");
  flag_p2_a: assert property (cap[3] |=> stat[10])
    else $error("probe 2 falling flag not set");
  src_index_a: assert property (ctrl[2] && $past(ctrl[2]) && $rose(index_pulse_i) &&
                                ctrl[0] && ctrl[4] && ctrl[1] |-> cap[0])
    else $error("probe 1 index source edge not captured");
  src_b_a: assert property (!ctrl[10] && !$past(ctrl[10]) && ctrl[8] && ctrl[12] && ctrl[9] &&
                            $rose(external_probe_input_b_i ~^ pol[1]) |-> cap[2])
    else $error("probe 2 external source edge not captured");
  din_lvl_a: assert property (wr == 1'b0 && rd_setup && idx == `TPL_IDX_DIN |=>
                              prdata_o[27:26] == $past(ext_lvl))
    else $error("digital input status read wrong");

  // ==========================================
  // capture and hold, remaining channels
  cap_pos1_a: assert property (
    cap[1] |=> pos_r[1] == $past(position_i))
    else $error("probe 1 falling capture stored wrong position");
  cap_pos2_a: assert property (
    cap[2] |=> pos_r[2] == $past(position_i))
    else $error("probe 2 rising capture stored wrong position");
  cap_pos3_a: assert property (
    cap[3] |=> pos_r[3] == $past(position_i))
    else $error("probe 2 falling capture stored wrong position");
  hold_pos0_a: assert property (
    !cap[0] |=> $stable(pos_r[0]))
    else $error("probe 1 rising position changed without capture");
  hold_pos1_a: assert property (
    !cap[1] |=> $stable(pos_r[1]))
    else $error("probe 1 falling position changed without capture");
  hold_pos2_a: assert property (
    !cap[2] |=> $stable(pos_r[2]))
    else $error("probe 2 rising position changed without capture");

  // ==========================================
  // edge counters and clearing
  cnt_inc0_a: assert property (
    cap[0] && !clr[0] |=> cnt[0] == $past(cnt[0]) + 1)
    else $error("probe 1 rising counter did not step");
  cnt_inc2_a: assert property (
    cap[2] && !clr[2] |=> cnt[2] == $past(cnt[2]) + 1)
    else $error("probe 2 rising counter did not step");
  cnt_inc3_a: assert property (
    cap[3] && !clr[3] |=> cnt[3] == $past(cnt[3]) + 1)
    else $error("probe 2 falling counter did not step");
  cnt_hold_a: assert property (
    !cap[0] && !clr[0] |=> $stable(cnt[0]))
    else $error("probe 1 rising counter moved without capture");
  cnt_clr0_a: assert property (
    clr[0] && !cap[0] |=> cnt[0] == 0 && !flg[0])
    else $error("config change did not clear probe 1 rising");
  cnt_clr1_a: assert property (
    clr[1] && !cap[1] |=> cnt[1] == 0 && !flg[1])
    else $error("config change did not clear probe 1 falling");
  cnt_clr3_a: assert property (
    clr[3] && !cap[3] |=> cnt[3] == 0 && !flg[3])
    else $error("config change did not clear probe 2 falling");
  mode_keep_a: assert property (
    wr && idx == `TPL_IDX_CTRL && ((next_ctrl ^ ctrl) & 16'h3535) == 16'h0000 |-> !clr[0] && !clr[2])
    else $error("write without enable, source or edge change cleared a probe");

  // ==========================================
  // single mode, flags and enables
  single1_a: assert property (
    !cfg[0].cont && flg[1] |-> !cap[1])
    else $error("single mode captured a second probe 1 falling edge");
  single2_a: assert property (
    !cfg[1].cont && flg[2] |-> !cap[2])
    else $error("single mode captured a second probe 2 rising edge");
  single3_a: assert property (
    !cfg[1].cont && flg[3] |-> !cap[3])
    else $error("single mode captured a second probe 2 falling edge");
  flag_p1f_a: assert property (
    cap[1] |=> stat[2])
    else $error("probe 1 falling flag not set");
  flag_p2r_a: assert property (
    cap[2] |=> stat[9])
    else $error("probe 2 rising flag not set");
  flag_clr_a: assert property (
    clr[1] && !cap[1] |=> !stat[2])
    else $error("config change left probe 1 falling flag set");
  disabled2_a: assert property (
    !ctrl[8] |-> !cap[2] && !cap[3])
    else $error("disabled probe 2 captured");

  // ==========================================
  // trigger sources and polarity
  // the selection must be steady for a cycle: the edge detector compares against the old source
  src_a_a: assert property (
    !ctrl[2] && !$past(ctrl[2]) && ctrl[0] && ctrl[4] && ctrl[1] &&
    $rose(external_probe_input_a_i ~^ pol[0]) |-> cap[0])
    else $error("probe 1 external rising edge not captured");
  src_idx2_a: assert property (
    ctrl[10] && $past(ctrl[10]) && ctrl[8] && ctrl[12] && ctrl[9] &&
    $rose(index_pulse_i) |-> cap[2])
    else $error("probe 2 index source edge not captured");
  fall_det_a: assert property (
    !ctrl[2] && !$past(ctrl[2]) && ctrl[0] && ctrl[5] && ctrl[1] &&
    $fell(external_probe_input_a_i ~^ pol[0]) |-> cap[1])
    else $error("probe 1 external falling edge not captured");

  // ==========================================
  // read path
  rd_pos_a: assert property (
    rd_setup && idx == `TPL_IDX_POS_P2R |=> prdata_o == 32'($past(pos_r[2])))
    else $error("probe 2 rising position read wrong");
  rd_cnt_a: assert property (
    rd_setup && idx == `TPL_IDX_CNT_P2F |=> prdata_o == 32'($past(cnt[3])))
    else $error("probe 2 falling counter read wrong");
  rd_stat_a: assert property (
    rd_setup && idx == `TPL_IDX_STAT |=> prdata_o[15:0] == $past(stat))
    else $error("status word read wrong");
endmodule // tpl_probe_latch

// ### tpl_probe_latch_test.sv
// self-checking bench of the touch-probe latch
`timescale 1ns/1ps
`include "tpl_params.svh"
module tpl_probe_latch_test;
  // ====
  // signals
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  tpl_pkg::tpl_apb_req_t req = '0;
  logic pready, pslverr, irq, ext_a, ext_b, index, err;
  logic [31:0] prdata, position, got;
  logic [2:0] lvl = 3'h0;
  logic [31:0] pos = 32'h0;
  int miscompares = 0;
  int tests_run = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  tpl_probe_source i_tpl_probe_source (.clk_sys_i(clk_sys_i), .lvl_i(lvl), .pos_i(pos),
    .ext_a_o(ext_a), .ext_b_o(ext_b), .index_o(index), .position_o(position));
  tpl_probe_latch i_tpl_probe_latch (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .apb_req_i(req),
    .pready_o(pready), .pslverr_o(pslverr), .prdata_o(prdata), .external_probe_input_a_i(ext_a),
    .external_probe_input_b_i(ext_b), .index_pulse_i(index), .position_i(position), .irq_o(irq));
  // ====
  // shared tasks
  task automatic close_out();
    $display("mismatches %0d of %0d checks", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t %s got %h want %h", $time, m, g, e);
    end
  endtask
  // setup starts one edge after entry, so a release and the next setup never share a time step
  task automatic apb(input logic w, input logic [15:0] ix, input logic [31:0] wd);
    @(posedge clk_sys_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {ix, 2'b00}, pwdata: wd, pstrb: 4'hf};
    @(posedge clk_sys_i);
    req.penable <= 1'b1;
    @(posedge clk_sys_i);
    for (int i = 0; pready !== 1'b1; i++) begin
      if (i == 8) begin
        miscompares++;
        close_out();
      end
      @(posedge clk_sys_i);
    end
    got = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] ix, input logic [31:0] d);
    apb(1'b1, ix, d);
  endtask
  task automatic rd(input logic [15:0] ix, input logic [31:0] e, input string m);
    apb(1'b0, ix, 32'h0);
    chk(got, e, m);
  endtask
  task automatic irq_is(input logic e, input string m);
    @(negedge clk_sys_i);
    chk({31'h0, irq}, {31'h0, e}, m);
  endtask
  // one cycle in the partner, one to detect, one to show
  task automatic drive(input logic [2:0] l, input logic [31:0] p);
    @(posedge clk_sys_i);
    lvl <= l;
    pos <= p;
    @(posedge clk_sys_i);
    // position moves on right after the detection edge, so a late sample would show
    pos <= ~p;
    repeat (2) @(posedge clk_sys_i);
  endtask
  // ====
  // scenarios
  task automatic t_reset();
    rd(`TPL_IDX_CTRL, 32'h0, "ctrl reset");
    rd(`TPL_IDX_STAT, 32'h0, "status reset");
    rd(`TPL_IDX_POL, 32'h3, "polarity reset");
    apb(1'b0, 16'h0100, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
  endtask
  task automatic t_single();
    wr(`TPL_IDX_CTRL, 32'h0031);
    rd(`TPL_IDX_STAT, 32'h0001, "enable mirror");
    drive(3'b011, 32'h11);
    rd(`TPL_IDX_POS_P1R, 32'h11, "p1 rise pos");
    rd(`TPL_IDX_CNT_P1R, 32'h1, "p1 rise count");
    drive(3'b000, 32'h22);
    rd(`TPL_IDX_STAT, 32'h0007, "p1 flags, p2 off");
    rd(`TPL_IDX_POS_P1F, 32'h22, "p1 fall pos");
    drive(3'b001, 32'h33);
    rd(`TPL_IDX_POS_P1R, 32'h11, "single holds");
    rd(`TPL_IDX_CNT_P1R, 32'h1, "single count");
    wr(`TPL_IDX_CTRL, 32'h0030);
    wr(`TPL_IDX_CTRL, 32'h0031);
    rd(`TPL_IDX_CNT_P1R, 32'h0, "rearm clears");
    drive(3'b000, 32'h44);
    rd(`TPL_IDX_POS_P1F, 32'h44, "rearmed capture");
  endtask
  task automatic t_cont();
    wr(`TPL_IDX_CTRL, 32'h1737);
    drive(3'b100, 32'h55);
    drive(3'b011, 32'h66);
    drive(3'b100, 32'h77);
    rd(`TPL_IDX_POS_P1R, 32'h77, "index rise pos");
    rd(`TPL_IDX_POS_P1F, 32'h66, "index fall pos");
    rd(`TPL_IDX_CNT_P1R, 32'h2, "p1 cont count");
    rd(`TPL_IDX_CNT_P2R, 32'h2, "p2 cont count");
    rd(`TPL_IDX_CNT_P2F, 32'h0, "p2 fall off");
    rd(`TPL_IDX_POS_P2R, 32'h77, "p2 rise pos");
    rd(`TPL_IDX_STAT, 32'h0307, "both flags");
  endtask
  // input a inverted: a pin rise is a falling edge
  task automatic t_pol();
    wr(`TPL_IDX_POL, 32'h2);
    wr(`TPL_IDX_CTRL, 32'h0021);
    drive(3'b011, 32'h88);
    rd(`TPL_IDX_DIN, 32'h0c000000, "pin levels");
    rd(`TPL_IDX_POS_P1F, 32'h88, "inverted edge");
    drive(3'b000, 32'h99);
    rd(`TPL_IDX_CNT_P1R, 32'h0, "rise disabled");
    rd(`TPL_IDX_CNT_P1F, 32'h1, "one fall");
    wr(`TPL_IDX_CTRL, 32'h3333);
    drive(3'b011, 32'hbb);
    drive(3'b000, 32'hcc);
    rd(`TPL_IDX_POS_P2R, 32'hbb, "p2 pin b rise");
    rd(`TPL_IDX_POS_P2F, 32'hcc, "p2 pin b fall");
    rd(`TPL_IDX_POS_P1R, 32'hcc, "inverted rise");
    rd(`TPL_IDX_CNT_P1F, 32'h1, "edge change clears");
    wr(`TPL_IDX_CTRL, 32'h3131);
    rd(`TPL_IDX_CNT_P1F, 32'h1, "mode change keeps");
  endtask
  task automatic t_irq();
    wr(`TPL_IDX_IRQ_EN, 32'h2);
    wr(`TPL_IDX_IRQ_CLR, 32'hf);
    rd(`TPL_IDX_IRQ_STAT, 32'h0, "irq cleared");
    irq_is(1'b0, "irq low");
    wr(`TPL_IDX_CTRL, 32'h0020);
    wr(`TPL_IDX_CTRL, 32'h0021);
    drive(3'b001, 32'haa);
    irq_is(1'b1, "irq raised");
    rd(`TPL_IDX_IRQ_STAT, 32'h2, "irq status");
    wr(`TPL_IDX_IRQ_EN, 32'h0);
    irq_is(1'b0, "irq masked");
    wr(`TPL_IDX_IRQ_EN, 32'h2);
    irq_is(1'b1, "irq unmasked");
    wr(`TPL_IDX_IRQ_CLR, 32'h2);
    irq_is(1'b0, "irq after clear");
  endtask
  // ====
  // main sequence
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_reset();
    t_single();
    t_cont();
    t_pol();
    t_irq();
    close_out();
  end
endmodule // tpl_probe_latch_test

// ### tpl_probe_source.sv
// partner model: probe pins, encoder index pulse and position source
`timescale 1ns/1ps
module tpl_probe_source (
  // clock
  input wire logic clk_sys_i,
  // commanded levels {index, b, a} and position
  input wire logic [2:0] lvl_i,
  input wire logic [31:0] pos_i,
  // towards the block
  output logic ext_a_o,
  output logic ext_b_o,
  output logic index_o,
  output logic [31:0] position_o
);
  // ====
  // outputs move only after an edge, as the block takes its inputs as synchronous
  initial begin
    {index_o, ext_b_o, ext_a_o} = 3'h0;
    position_o = 32'h0;
  end
  always @(posedge clk_sys_i) begin
    {index_o, ext_b_o, ext_a_o} <= lvl_i;
    position_o <= pos_i;
  end
endmodule // tpl_probe_source
